//--- logic/ops_cpu_end.sv
// controlling cpu end: apb registers drive the link to the module
// assumes an apb master on the same clock
`include "ops_defs.svh"
module ops_cpu_end (
    // clock and reset
    input  wire logic        clk_in,
    input  wire logic        reset_in,
    // apb slave
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [11:0] paddr_in,
    input  wire logic [31:0] pwdata_in,
    output logic [31:0]      prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    output logic             irq_out,
    // link to module
    ops_link_if.cpu          link
);
    logic [31:0]                rec_ff;
    logic [7:0]                 out_ff;
    logic                       run_ff;
    logic                       send_req_ff;
    logic [1:0]                 idx_ff;
    logic [`OPS_IRQ_BITS-1:0]   irq_stat_ff;
    logic [`OPS_IRQ_BITS-1:0]   irq_en_ff;
    logic                       last_err_ff;
    ops_pkg::ops_send_state_t   state_ff;
    logic                       wr;
    logic                       rd;
    logic [`OPS_IRQ_BITS-1:0]   ev;

    assign wr = psel_in && penable_in && pwrite_in;
    assign rd = psel_in && !penable_in && !pwrite_in;

    // register writes; run entry or send bit triggers record transfer
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            rec_ff      <= 32'h0000_0000;
            out_ff      <= 8'h00;
            run_ff      <= 1'b0;
            send_req_ff <= 1'b0;
            irq_en_ff   <= '0;
        end else begin
            if (state_ff == ops_pkg::OPS_SEND) begin
                send_req_ff <= 1'b0;
            end
            if (wr) begin
                if (paddr_in == `OPS_REG_CTRL) begin
                    run_ff <= pwdata_in[`OPS_CTRL_RUN];
                    if ((pwdata_in[`OPS_CTRL_RUN] && !run_ff) || pwdata_in[`OPS_CTRL_SEND]) begin
                        send_req_ff <= 1'b1; // RL2 RL5
                    end
                end else if (paddr_in == `OPS_REG_OUT_BYTE) begin
                    out_ff <= pwdata_in[7:0];
                end else if (paddr_in == `OPS_REG_REC_LO) begin
                    rec_ff <= pwdata_in;
                end else if (paddr_in == `OPS_REG_IRQ_EN) begin
                    irq_en_ff <= pwdata_in[`OPS_IRQ_BITS-1:0];
                end
            end
        end
    end

    // record transfer sequencer, bytes 0 to 3
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            state_ff <= ops_pkg::OPS_IDLE;
            idx_ff   <= 2'h0;
        end else begin
            case (state_ff)
                ops_pkg::OPS_IDLE: begin
                    idx_ff <= 2'h0;
                    if (send_req_ff) begin
                        state_ff <= ops_pkg::OPS_SEND;
                    end
                end
                ops_pkg::OPS_SEND: begin
                    idx_ff <= idx_ff + 2'h1;
                    if (idx_ff == 2'h3) begin
                        state_ff <= ops_pkg::OPS_WAIT; // RL4
                    end
                end
                default: begin
                    if (link.rec_ack) begin
                        state_ff <= ops_pkg::OPS_IDLE;
                    end
                end
            endcase
        end
    end

    // link drive, all from flip-flops
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            link.cpu_run   <= 1'b0;
            link.out_valid <= 1'b0;
            link.out_byte  <= 8'h00;
            link.rec_valid <= 1'b0;
            link.rec_idx   <= 2'h0;
            link.rec_data  <= 8'h00;
            link.rec_last  <= 1'b0;
        end else begin
            // run raised only after record went out
            link.cpu_run   <= run_ff && (state_ff == ops_pkg::OPS_IDLE) && !send_req_ff
                              ? 1'b1 : (run_ff ? link.cpu_run : 1'b0); // RL2
            link.out_valid <= run_ff;
            link.out_byte  <= out_ff;
            link.rec_valid <= (state_ff == ops_pkg::OPS_SEND);
            link.rec_idx   <= idx_ff;
            link.rec_data  <= rec_ff[idx_ff*8 +: 8]; // RL8 RL10
            link.rec_last  <= (state_ff == ops_pkg::OPS_SEND) && (idx_ff == 2'h3);
        end
    end

    // sticky status, set wins over clear
    assign ev = {link.rec_err, link.rec_ack && !link.rec_err};
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            irq_stat_ff <= '0;
            last_err_ff <= 1'b0;
            irq_out     <= 1'b0;
        end else begin
            if (link.rec_ack) begin
                last_err_ff <= link.rec_err;
            end
            if (wr && paddr_in == `OPS_REG_IRQ_CLR) begin
                irq_stat_ff <= (irq_stat_ff & ~pwdata_in[`OPS_IRQ_BITS-1:0]) | ev;
            end else begin
                irq_stat_ff <= irq_stat_ff | ev;
            end
            irq_out <= |(irq_stat_ff & irq_en_ff);
        end
    end

    // apb read data and no wait state
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            prdata_out  <= 32'h0000_0000;
            pready_out  <= 1'b0;
            pslverr_out <= 1'b0;
        end else begin
            pready_out  <= psel_in && !penable_in;
            pslverr_out <= psel_in && !penable_in && (paddr_in > `OPS_REG_IRQ_EN);
            if (rd) begin
                if (paddr_in == `OPS_REG_CTRL) begin
                    prdata_out <= {31'h0, run_ff};
                end else if (paddr_in == `OPS_REG_OUT_BYTE) begin
                    prdata_out <= {24'h0, out_ff};
                end else if (paddr_in == `OPS_REG_REC_LO) begin
                    prdata_out <= rec_ff;
                end else if (paddr_in == `OPS_REG_STATUS) begin
                    prdata_out <= {29'h0, last_err_ff, link.cpu_run,
                                   state_ff != ops_pkg::OPS_IDLE};
                end else if (paddr_in == `OPS_REG_IRQ_STAT) begin
                    prdata_out <= {30'h0, irq_stat_ff};
                end else if (paddr_in == `OPS_REG_IRQ_EN) begin
                    prdata_out <= {30'h0, irq_en_ff};
                end else begin
                    prdata_out <= 32'h0000_0000;
                end
            end
        end
    end
endmodule // ops_cpu_end

//--- logic/ops_defs.svh
// constants for the output port with stop reaction
// assumes inclusion by both ends and by the bench
`ifndef OPS_DEFS_SVH
`define OPS_DEFS_SVH
`define OPS_CHANNELS          8
`define OPS_REC_BYTES         4
`define OPS_REC_NUMBER        8'h01
`define OPS_PIDX_STOP_SEL     2'h0
`define OPS_PIDX_SUBST        2'h1
`define OPS_PIDX_UNUSED_A     2'h2
`define OPS_PIDX_UNUSED_B     2'h3
`define OPS_PARAM_RESET       8'h00
`define OPS_BIT_HOLD          0
`define OPS_BIT_SUBST         1
`define OPS_STOP_SUPPORTED    8'hC3
`define OPS_UNUSED_SUPPORTED  8'h00
`define OPS_REG_CTRL          12'h000
`define OPS_REG_OUT_BYTE      12'h004
`define OPS_REG_REC_LO        12'h008
`define OPS_REG_STATUS        12'h00C
`define OPS_REG_IRQ_STAT      12'h010
`define OPS_REG_IRQ_CLR       12'h014
`define OPS_REG_IRQ_EN        12'h018
`define OPS_CTRL_RUN          0
`define OPS_CTRL_SEND         1
`define OPS_IRQ_SENT          0
`define OPS_IRQ_REJECT        1
`define OPS_IRQ_BITS          2
`endif

//--- logic/ops_link_if.sv
// backplane link between controlling cpu and output module
// assumes one clock shared by both ends
interface ops_link_if;
    logic       cpu_run;
    logic       out_valid;
    logic [7:0] out_byte;
    logic       rec_valid;
    logic [1:0] rec_idx;
    logic [7:0] rec_data;
    logic       rec_last;
    logic       rec_ack;
    logic       rec_err;
    modport cpu (output cpu_run, out_valid, out_byte, rec_valid, rec_idx, rec_data,
                 rec_last, input rec_ack, rec_err);
    modport module_end (input cpu_run, out_valid, out_byte, rec_valid, rec_idx, rec_data,
                        rec_last, output rec_ack, rec_err);
endinterface

//--- logic/ops_output_module.sv
// output module end: eight output channels with cpu stop reaction
// assumes the cpu end drives the link on the same clock
//
// Behaviour
// RL1: fault led lit while no record held
// RL2: record accepted and applied on arrival
// RL3: unsupported values rejected, fault raised
// RL4: one record, number one, four bytes
// RL5: record rewrite adopted while running
// RL6: byte0 bit0 holds last value at stop
// RL7: byte0 bit1 drives substitutes at stop
// RL8: byte0 bits 6,7 reserved, no function
// RL9: byte1 bit n is channel n substitute
// RL10: cpu sets hold or substitute, never both
// RL11: hold freezes outputs at stop moment
// RL12: substitution uses byte1 per channel
// RL13: running outputs follow byte, leds follow
// RL14: neither bit set drives all low
`include "ops_defs.svh"
module ops_output_module #(
    parameter int CHANNELS = `OPS_CHANNELS
) (
    // clock and reset
    input  wire logic                clk_in,
    input  wire logic                reset_in,
    // link from cpu
    ops_link_if.module_end           link,
    // process side
    output logic [CHANNELS-1:0]      output_image_bits_out,
    output logic [CHANNELS-1:0]      channel_led_out,
    output logic                     group_fault_led_out
);
    logic [7:0]          stop_reaction_select_ff;
    logic [7:0]          substitute_levels_ff;
    logic [7:0]          stage_ff [`OPS_REC_BYTES];
    logic                param_ok_ff;
    logic                param_bad_ff;
    logic [CHANNELS-1:0] run_image_ff;
    logic                run_d_ff;
    logic                stage_good;
    logic [CHANNELS-1:0] nxt_image;

    // staging of record bytes, checked as a whole on the last byte
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            for (int i = 0; i < `OPS_REC_BYTES; i++) begin
                stage_ff[i] <= `OPS_PARAM_RESET;
            end
        end else if (link.rec_valid) begin
            stage_ff[link.rec_idx] <= link.rec_data; // RL4
        end
    end

    // validation against last byte merged with staged ones
    always_comb begin
        logic [7:0] b0;
        logic [7:0] b2;
        logic [7:0] b3;
        b0 = (link.rec_idx == `OPS_PIDX_STOP_SEL) ? link.rec_data : stage_ff[0];
        b2 = (link.rec_idx == `OPS_PIDX_UNUSED_A) ? link.rec_data : stage_ff[2];
        b3 = (link.rec_idx == `OPS_PIDX_UNUSED_B) ? link.rec_data : stage_ff[3];
        // bits 2..5 unknown; both options together unsupported
        stage_good = ((b0 & ~`OPS_STOP_SUPPORTED) == 8'h00)                   // RL3
                   && !(b0[`OPS_BIT_HOLD] && b0[`OPS_BIT_SUBST])              // RL10
                   && ((b2 | b3) == `OPS_UNUSED_SUPPORTED);                   // RL3
    end

    // apply record: on its last byte, whether running or stopped
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            stop_reaction_select_ff <= `OPS_PARAM_RESET; // RL6
            substitute_levels_ff    <= `OPS_PARAM_RESET; // RL9
            param_ok_ff             <= 1'b0;
            param_bad_ff            <= 1'b0;
        end else if (link.rec_valid && link.rec_last) begin
            if (stage_good) begin
                // reserved bits 6 and 7 stored but unused
                stop_reaction_select_ff <= (link.rec_idx == `OPS_PIDX_STOP_SEL) ?
                                           link.rec_data : stage_ff[0]; // RL2 RL5 RL8
                substitute_levels_ff    <= (link.rec_idx == `OPS_PIDX_SUBST) ?
                                           link.rec_data : stage_ff[1]; // RL2 RL5
                param_ok_ff             <= 1'b1;
                param_bad_ff            <= 1'b0;
            end else begin
                param_bad_ff            <= 1'b1; // RL3
            end
        end
    end

    // acknowledge pulse for each record, error pulse for a rejected one
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            link.rec_ack <= 1'b0;
            link.rec_err <= 1'b0;
        end else begin
            link.rec_ack <= link.rec_valid && link.rec_last;
            link.rec_err <= link.rec_valid && link.rec_last && !stage_good; // RL3
        end
    end

    // latest output byte from the running cpu
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            run_image_ff <= '0;
        end else if (link.out_valid && link.cpu_run) begin
            run_image_ff <= link.out_byte[CHANNELS-1:0]; // RL13
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            run_d_ff <= 1'b0;
        end else begin
            run_d_ff <= link.cpu_run;
        end
    end

    // output selection per stop reaction
    always_comb begin
        nxt_image = output_image_bits_out;
        if (link.cpu_run) begin
            nxt_image = run_image_ff; // RL13
        end else if (run_d_ff) begin
            if (stop_reaction_select_ff[`OPS_BIT_HOLD]) begin
                nxt_image = output_image_bits_out; // RL6 RL11
            end else if (stop_reaction_select_ff[`OPS_BIT_SUBST]) begin
                nxt_image = substitute_levels_ff[CHANNELS-1:0]; // RL7 RL9 RL12
            end else begin
                nxt_image = '0; // RL14
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            output_image_bits_out <= '0;
            channel_led_out       <= '0;
            group_fault_led_out   <= 1'b1;
        end else begin
            output_image_bits_out <= nxt_image;
            channel_led_out       <= nxt_image; // RL13
            group_fault_led_out   <= !param_ok_ff || param_bad_ff; // RL1 RL3
        end
    end
endmodule // ops_output_module

//--- logic/ops_pkg.sv
// types used by the cpu end of the output port
// assumes ops_defs.svh for the numeric constants
package ops_pkg;
    typedef enum logic [1:0] {
        OPS_IDLE,
        OPS_SEND,
        OPS_WAIT
    } ops_send_state_t;
endpackage

//--- sim/ops_link_monitor.sv
// checker for the backplane link between the two ends
// assumes plain copies of the link signals and the one shared clock
module ops_link_monitor (
    // clock and reset
    input  wire logic       clk_in,
    input  wire logic       reset_in,
    // link signals
    input  wire logic       cpu_run,
    input  wire logic       out_valid,
    input  wire logic [7:0] out_byte,
    input  wire logic       rec_valid,
    input  wire logic [1:0] rec_idx,
    input  wire logic [7:0] rec_data,
    input  wire logic       rec_last,
    input  wire logic       rec_ack,
    input  wire logic       rec_err
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (reset_in);
    // bytes one to three follow byte zero without a gap
    sequence s_rest;
        rec_valid && rec_idx == 2'h1 ##1 rec_valid && rec_idx == 2'h2
            ##1 rec_valid && rec_idx == 2'h3 && rec_last;
    endsequence
    sequence s_last;
        rec_valid && rec_last;
    endsequence
    // byte zero asking for hold and substitute together
    sequence s_both_opts;
        rec_valid && rec_idx == 2'h0 && rec_data[0] && rec_data[1];
    endsequence
    chk_byte_order: assert property (rec_valid && rec_idx == 2'h0 |=> s_rest)
        else $error("record bytes out of order");
    chk_last_is_three: assert property (s_last |-> rec_idx == 2'h3)
        else $error("last marker not on byte three");
    chk_no_gap: assert property (rec_valid && !rec_last |=> rec_valid)
        else $error("gap inside record");
    chk_ack_after_last: assert property (s_last |=> rec_ack)
        else $error("no acknowledge after last byte");
    chk_ack_single: assert property (rec_ack |=> !rec_ack)
        else $error("acknowledge longer than one cycle");
    chk_ack_cause: assert property (rec_ack |-> $past(rec_last) && $past(rec_valid))
        else $error("acknowledge without a record");
    chk_err_with_ack: assert property (rec_err |-> rec_ack)
        else $error("reject without acknowledge");
    chk_run_after_rec: assert property ($rose(cpu_run) |-> !rec_valid)
        else $error("run raised during record transfer");
    chk_both_rejected: assert property (s_both_opts |-> ##4 rec_err)
        else $error("record with both stop options not rejected");
    chk_run_has_byte: assert property (cpu_run |-> out_valid)
        else $error("run without output byte valid");
endmodule // ops_link_monitor

//--- sim/tb.sv
// bench for both ends of the output port joined by the link
// assumes ops_defs.svh on the include path and a 10 MHz clock
`include "ops_defs.svh"
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_in, reset_in, psel, pen, pwr, perr, pready, pslverr, irq, flt;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0]  outs, leds;
    int          n_errors, compares;
    logic [48:0] rows [8];
    ops_link_if link ();
    ops_cpu_end i_ops_cpu_end (.clk_in(clk_in), .reset_in(reset_in), .psel_in(psel),
        .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata),
        .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .irq_out(irq),
        .link(link));
    ops_output_module i_ops_output_module (.clk_in(clk_in), .reset_in(reset_in),
        .link(link), .output_image_bits_out(outs), .channel_led_out(leds),
        .group_fault_led_out(flt));
    ops_link_monitor i_ops_link_monitor (.clk_in(clk_in), .reset_in(reset_in),
        .cpu_run(link.cpu_run), .out_valid(link.out_valid), .out_byte(link.out_byte),
        .rec_valid(link.rec_valid), .rec_idx(link.rec_idx), .rec_data(link.rec_data),
        .rec_last(link.rec_last), .rec_ack(link.rec_ack), .rec_err(link.rec_err));
    initial begin
        clk_in = 1'h0;
        forever #50 clk_in = ~clk_in;
    end
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic results();
        $display("compares %0d mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // one apb transfer, read data and error taken at the answering edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge clk_in);
        psel <= 1'h1;
        pen <= 1'h0;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_in);
        pen <= 1'h1;
        i = 0;
        do begin
            @(posedge clk_in);
            i++;
        end while (pready !== 1'h1 && i < 20);
        if (pready !== 1'h1) begin
            n_errors++;
            results();
        end
        rd = prdata;
        perr = pslverr;
        psel <= 1'h0;
        pen <= 1'h0;
    endtask
    task automatic wait_irq();
        int i;
        rd = 32'h0;
        for (i = 0; i < 30 && rd === 32'h0; i++) apb(1'h0, `OPS_REG_IRQ_STAT, 32'h0);
        if (rd === 32'h0) begin
            n_errors++;
            results();
        end
        @(negedge clk_in);
    endtask
    initial begin
        repeat (20000) @(posedge clk_in);
        n_errors++;
        results();
    end
    initial begin
        // record word, running byte, level after stop, fault expected
        rows = '{{32'h0000A501, 8'h3C, 8'h3C, 1'h0}, {32'h0000A502, 8'h3C, 8'hA5, 1'h0},
                 {32'h0000FF00, 8'h3C, 8'h00, 1'h0}, {32'h00000FC2, 8'h81, 8'h0F, 1'h0},
                 {32'h0000FF03, 8'h81, 8'h0F, 1'h1}, {32'h00000004, 8'h81, 8'h0F, 1'h1},
                 {32'h00020001, 8'h81, 8'h0F, 1'h1}, {32'h01000002, 8'h81, 8'h0F, 1'h1}};
        {psel, pen, pwr, paddr, pwdata} = '0;
        reset_in = 1'h1;
        repeat (10) @(posedge clk_in);
        reset_in <= 1'h0;
        @(negedge clk_in);
        chk("fault_led", 32'h1, flt);
        chk("outputs", 32'h0, outs);
        chk("irq", 32'h0, irq);
        $display("reset test done");
        apb(1'h1, `OPS_REG_IRQ_EN, 32'h3);
        for (int r = 0; r < 8; r++) begin
            apb(1'h1, `OPS_REG_REC_LO, rows[r][48:17]);
            apb(1'h1, `OPS_REG_CTRL, 32'h1);
            wait_irq();
            chk("irq_stat", rows[r][0] ? 32'h2 : 32'h1, rd);
            chk("irq", 32'h1, irq);
            chk("fault_led", rows[r][0], flt);
            apb(1'h1, `OPS_REG_OUT_BYTE, rows[r][16:9]);
            repeat (4) @(negedge clk_in);
            chk("outputs", rows[r][16:9], outs);
            chk("leds", rows[r][16:9], leds);
            apb(1'h1, `OPS_REG_IRQ_CLR, 32'h3);
            apb(1'h1, `OPS_REG_CTRL, 32'h0);
            apb(1'h1, `OPS_REG_OUT_BYTE, ~rows[r][16:9]);
            repeat (4) @(negedge clk_in);
            chk("stop_outputs", rows[r][8:1], outs);
            chk("irq", 32'h0, irq);
            $display("row %0d done", r);
        end
        apb(1'h1, `OPS_REG_REC_LO, 32'h00005502);
        apb(1'h1, `OPS_REG_CTRL, 32'h1);
        wait_irq();
        apb(1'h1, `OPS_REG_IRQ_CLR, 32'h3);
        apb(1'h1, `OPS_REG_REC_LO, 32'h0000AA02);
        apb(1'h1, `OPS_REG_CTRL, 32'h3);
        wait_irq();
        chk("fault_led", 32'h0, flt);
        chk("irq_stat", 32'h1, rd);
        apb(1'h1, `OPS_REG_CTRL, 32'h0);
        repeat (4) @(negedge clk_in);
        chk("stop_outputs", 32'hAA, outs);
        $display("live rewrite test done");
        apb(1'h1, `OPS_REG_IRQ_CLR, 32'h3);
        apb(1'h1, `OPS_REG_IRQ_EN, 32'h0);
        apb(1'h1, `OPS_REG_CTRL, 32'h3);
        wait_irq();
        chk("irq_masked", 32'h0, irq);
        chk("irq_stat", 32'h1, rd);
        apb(1'h1, `OPS_REG_CTRL, 32'h0);
        apb(1'h0, 12'h01C, 32'h0);
        chk("pslverr", 32'h1, perr);
        chk("unmapped_read", 32'h0, rd);
        $display("mask and unmapped test done");
        apb(1'h1, `OPS_REG_IRQ_CLR, 32'h3);
        apb(1'h1, `OPS_REG_CTRL, 32'h1);
        wait_irq();
        apb(1'h1, `OPS_REG_OUT_BYTE, 32'h5A);
        apb(1'h0, `OPS_REG_STATUS, 32'h0);
        chk("status", 32'h2, rd);
        repeat (4) @(negedge clk_in);
        chk("outputs", 32'h5A, outs);
        @(posedge clk_in);
        reset_in <= 1'h1;
        repeat (2) @(posedge clk_in);
        reset_in <= 1'h0;
        @(negedge clk_in);
        chk("fault_led", 32'h1, flt);
        chk("outputs", 32'h0, outs);
        chk("leds", 32'h0, leds);
        apb(1'h0, `OPS_REG_IRQ_STAT, 32'h0);
        chk("irq_stat", 32'h0, rd);
        apb(1'h0, `OPS_REG_STATUS, 32'h0);
        chk("status", 32'h0, rd);
        $display("mid-run reset test done");
        results();
    end
endmodule // tb
